// File: src/mme_decoder.sv
module mme_decoder
(
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_NRST,
  input  wire logic                 i_POR_N,
  input  wire logic                 i_RESET_PIN_N,
  input  wire logic                 i_RESET_PIN_TST,
  input  wire mme_pkg::mme_irq_lvl_t i_IRQ_LEVEL,
  input  wire logic [7:0]           i_RESET_VEC_HI,
  input  wire logic [7:0]           i_RESET_VEC_LO,
  input  wire logic                 i_ENTRY_STRAP_PIN_A,
  input  wire logic                 i_ENTRY_STRAP_PIN_B,
  input  wire logic                 i_MONITOR_SERIAL_PIN,
  input  wire logic                 i_COMM_SELECT_PIN,
  output logic                      o_MONITOR_MODE,
  output logic                      o_PLL_ENABLE,
  output logic                      o_CLK_BYPASS,
  output logic                      o_WATCHDOG_DISABLE,
  output logic                      o_COMM_PARALLEL,
  output logic                      o_EXTRA_RESET,
  output logic [1:0]                o_ENTRY_PATH
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic rst_pin_s;
  logic por_s;

  mme_sync2 u_sync_rst
  (
    .I_CLK_SYS (I_CLK_SYS),
    .I_NRST    (I_NRST),
    .i_d       (i_RESET_PIN_N),
    .o_q       (rst_pin_s)
  );

  mme_sync2 u_sync_por
  (
    .I_CLK_SYS (I_CLK_SYS),
    .I_NRST    (I_NRST),
    .i_d       (i_POR_N),
    .o_q       (por_s)
  );

  logic rst_pin_d_ff;
  logic por_d_ff;
  logic extra_done_ff;
  logic extra_ff;
  mme_pkg::mme_decision_t dec_ff;
  logic wd_dis_ff;
  logic bypass_ff;

  // ----------------------------------------------------------------
  // entry decode
  // ----------------------------------------------------------------
  function automatic logic is_blank(input logic [7:0] b);
    is_blank = (b == mme_pkg::BLANK_BYTE);
  endfunction : is_blank

  wire vec_blank  = is_blank(i_RESET_VEC_HI) && is_blank(i_RESET_VEC_LO);
  wire irq_tst    = (i_IRQ_LEVEL == mme_pkg::MME_IRQ_TST);
  // straps only count on the high voltage path
  wire straps_ok  = i_ENTRY_STRAP_PIN_A && !i_ENTRY_STRAP_PIN_B;
  wire path_hv    = irq_tst && straps_ok;
  wire path_vdd   = !irq_tst && vec_blank
                    && (i_IRQ_LEVEL == mme_pkg::MME_IRQ_VDD);
  wire path_pll   = !irq_tst && vec_blank
                    && (i_IRQ_LEVEL == mme_pkg::MME_IRQ_GND);
  wire rst_rise   = rst_pin_s && !rst_pin_d_ff;
  wire por_rise   = por_s && !por_d_ff;
  // blank-vector monitor mode is sticky across pin resets
  wire sticky_mon = dec_ff.monitor && (dec_ff.path != mme_pkg::MME_PATH_HV);
  wire first_boot = !extra_done_ff;

  mme_pkg::mme_decision_t nxt_dec;
  always_comb
  begin
    nxt_dec = dec_ff;
    if (rst_rise && !sticky_mon)
    begin
      nxt_dec = mme_pkg::DECISION_RESET;
      nxt_dec.parallel = i_COMM_SELECT_PIN;
      if (path_hv)
      begin
        nxt_dec.monitor = 1'b1;
        nxt_dec.path    = mme_pkg::MME_PATH_HV;
      end
      else if (path_vdd)
      begin
        nxt_dec.monitor = 1'b1;
        nxt_dec.path    = mme_pkg::MME_PATH_VDD;
      end
      else if (path_pll)
      begin
        nxt_dec.monitor = 1'b1;
        nxt_dec.pll_on  = 1'b1;
        nxt_dec.path    = mme_pkg::MME_PATH_PLL;
      end
    end
  end

  // watchdog hold depends on path and live test voltage
  wire tst_live   = irq_tst || i_RESET_PIN_TST;
  wire nxt_wd_dis = !rst_pin_s
                    || (nxt_dec.monitor && (nxt_dec.path != mme_pkg::MME_PATH_HV))
                    || (nxt_dec.monitor && tst_live);

  // one extra reset pulse after the first blank-vector entry
  // a power-on rise in the same cycle discards the entry, so no pulse then
  wire nxt_extra  = rst_rise && !sticky_mon && first_boot && !por_rise
                    && (path_vdd || path_pll);

  // bypass is registered so the pin never glitches while path bits settle
  wire nxt_bypass = nxt_dec.monitor && (nxt_dec.path == mme_pkg::MME_PATH_HV)
                    && !por_rise;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_pin_d_ff  <= 1'b0;
      por_d_ff      <= 1'b0;
      dec_ff        <= mme_pkg::DECISION_RESET;
      wd_dis_ff     <= 1'b1;
      bypass_ff     <= 1'b0;
      extra_ff      <= 1'b0;
      extra_done_ff <= 1'b0;
    end
    else
    begin
      rst_pin_d_ff <= rst_pin_s;
      por_d_ff     <= por_s;
      // power-on clears even the sticky mode
      dec_ff       <= por_rise ? mme_pkg::DECISION_RESET : nxt_dec;
      wd_dis_ff    <= nxt_wd_dis;
      bypass_ff    <= nxt_bypass;
      extra_ff     <= nxt_extra;
      if (por_rise)
        extra_done_ff <= 1'b0;
      else if (nxt_extra)
        extra_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------------
  assign o_MONITOR_MODE     = dec_ff.monitor;
  assign o_PLL_ENABLE       = dec_ff.pll_on;
  // path one bypasses the generator: output equals crystal clock
  assign o_CLK_BYPASS       = bypass_ff;
  assign o_WATCHDOG_DISABLE = wd_dis_ff;
  assign o_COMM_PARALLEL    = dec_ff.parallel;
  assign o_EXTRA_RESET      = extra_ff;
  assign o_ENTRY_PATH       = dec_ff.path;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence rise_seq;
    rst_pin_s && !rst_pin_d_ff && !sticky_mon && !por_rise;
  endsequence

  pll_path_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq and path_pll |=> o_PLL_ENABLE && o_MONITOR_MODE)
    else $error("pll not enabled on grounded irq entry");

  hv_pll_off_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq and path_hv |=> !o_PLL_ENABLE && o_CLK_BYPASS)
    else $error("high voltage entry wrong clock path");

  vdd_path_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq and path_vdd |=> o_MONITOR_MODE && !o_PLL_ENABLE)
    else $error("supply irq entry wrong");

  strap_ign_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq and vec_blank && !irq_tst |=> o_MONITOR_MODE)
    else $error("straps blocked low voltage entry");

  user_mode_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq and !path_hv && !path_vdd && !path_pll
    |=> !o_MONITOR_MODE ##1 (!rst_pin_d_ff || !o_WATCHDOG_DISABLE))
    else $error("user mode not selected");

  blank_wd_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    o_MONITOR_MODE && o_ENTRY_PATH != 2'h1 && !por_rise |=> o_WATCHDOG_DISABLE)
    else $error("watchdog active in blank vector monitor");

  latch_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    !rst_rise && !por_rise |=> $stable(dec_ff))
    else $error("decision changed without reset rise");

  comm_sel_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    rise_seq |=> o_COMM_PARALLEL == $past(i_COMM_SELECT_PIN))
    else $error("comm type not latched");

  extra_once_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    o_EXTRA_RESET |=> !o_EXTRA_RESET [*2])
    else $error("extra reset repeated");

  hv_wd_live_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    dec_ff.monitor && (dec_ff.path == mme_pkg::MME_PATH_HV) && rst_pin_s && !rst_rise
    && !por_rise |=> o_WATCHDOG_DISABLE == $past(tst_live))
    else $error("watchdog hold not following test voltage");

endmodule : mme_decoder

// File: src/mme_pkg.sv
package mme_pkg;

  // ----------------------------------------------------------------
  // irq pin voltage class
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MME_IRQ_GND = 2'h0,
    MME_IRQ_VDD = 2'h1,
    MME_IRQ_TST = 2'h2
  } mme_irq_lvl_t;

  // ----------------------------------------------------------------
  // entry path
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MME_PATH_USER = 2'h0,
    MME_PATH_HV   = 2'h1,
    MME_PATH_VDD  = 2'h2,
    MME_PATH_PLL  = 2'h3
  } mme_path_t;

  // latched decision, carried as one bundle
  typedef struct packed
  {
    logic      monitor;
    logic      pll_on;
    logic      parallel;
    mme_path_t path;
  } mme_decision_t;

  localparam logic [7:0]   BLANK_BYTE       = 8'hFF;
  localparam int           MON_BAUD         = 9600;
  localparam int           EXT_CLK_HZ       = 9830400;
  localparam int           XTAL_HZ          = 32768;
  localparam int           PLL_BUS_HZ       = 2457600;
  localparam logic [4:0]   COMM_HOLD_CYCLES = 5'h18;
  localparam logic [1:0]   EXTRA_RESETS     = 2'h1;
  localparam mme_decision_t DECISION_RESET  = '{1'b0, 1'b0, 1'b0, MME_PATH_USER};

endpackage : mme_pkg

// File: src/mme_sync2.sv
// two-flop level synchroniser for the reset pin and the power-on input
module mme_sync2
(
  input  wire logic I_CLK_SYS,
  input  wire logic I_NRST,
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_ff;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  // first stage is read only by the second stage
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      meta_ff <= 1'b0;
      o_q     <= 1'b0;
    end
    else
    begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end

endmodule : mme_sync2

// File: verification/mme_host_model.sv
// host side: idles the serial line and drives comm select
module mme_host_model
(
  input  wire logic I_CLK_SYS,
  input  wire logic i_rst_pin_n,
  input  wire logic i_par,
  output logic      o_serial,
  output logic      o_comm_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] hold_ff;

  // ------------------------------------------------------------
  // host pin behaviour
  // ------------------------------------------------------------
  // serial line idles high whenever serial transfer is wanted
  assign o_serial = 1'b1;

  // hold count restarts while reset pin is low
  always_ff @(posedge I_CLK_SYS)
    if (!i_rst_pin_n)
      hold_ff <= mme_pkg::COMM_HOLD_CYCLES;
    else if (hold_ff != 5'h00)
      hold_ff <= hold_ff - 5'h01;

  // follows i_par through the hold, then freed high so a late sample would show
  assign o_comm_sel = i_par | (hold_ff == 5'h00);
endmodule : mme_host_model

// File: verification/mme_decoder_tb.sv
module mme_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk = 1'b0, nrst = 1'b0, por_n = 1'b0, rpin_n = 1'b0, rtst = 1'b0;
  mme_pkg::mme_irq_lvl_t irq = mme_pkg::MME_IRQ_VDD;
  logic [7:0]            vhi = 8'h12, vlo = 8'h12;
  logic                  sa = 1'b0, sb = 1'b0, par = 1'b0, ser, csel;
  logic                  mon, pll, byp, wd, cpar, ext;
  logic [1:0]            path;
  int                    n_fail = 0, total_checks = 0, n_ext = 0;

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end

  always #12.5 clk = ~clk;

  // count one-cycle extra reset pulses
  always @(posedge clk)
    if (ext === 1'b1)
      n_ext++;

  mme_host_model u_host
  (
    .I_CLK_SYS   (clk),
    .i_rst_pin_n (rpin_n),
    .i_par       (par),
    .o_serial    (ser),
    .o_comm_sel  (csel)
  );

  mme_decoder u_dut
  (
    .I_CLK_SYS            (clk),
    .I_NRST               (nrst),
    .i_POR_N              (por_n),
    .i_RESET_PIN_N        (rpin_n),
    .i_RESET_PIN_TST      (rtst),
    .i_IRQ_LEVEL          (irq),
    .i_RESET_VEC_HI       (vhi),
    .i_RESET_VEC_LO       (vlo),
    .i_ENTRY_STRAP_PIN_A  (sa),
    .i_ENTRY_STRAP_PIN_B  (sb),
    .i_MONITOR_SERIAL_PIN (ser),
    .i_COMM_SELECT_PIN    (csel),
    .o_MONITOR_MODE       (mon),
    .o_PLL_ENABLE         (pll),
    .o_CLK_BYPASS         (byp),
    .o_WATCHDOG_DISABLE   (wd),
    .o_COMM_PARALLEL      (cpar),
    .o_EXTRA_RESET        (ext),
    .o_ENTRY_PATH         (path)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // pins are set while reset pin is low, then reset pin is released
  task automatic entry(input mme_pkg::mme_irq_lvl_t l, input logic [7:0] v,
                       input logic a, input logic b, input logic p);
    @(negedge clk);
    rpin_n = 1'b0;
    irq = l;
    vhi = v;
    vlo = v;
    sa = a;
    sb = b;
    par = p;
    repeat (4) @(negedge clk);
    rpin_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : entry

  // order: monitor, pll, bypass, watchdog off, parallel, path
  task automatic chk(input logic [6:0] e);
    `CHK({mon, pll, byp, wd, cpar, path}, e)
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_user();
    entry(mme_pkg::MME_IRQ_VDD, 8'h12, 1'b0, 1'b0, 1'b0);
    chk(7'h00);
  endtask : t_user

  // high voltage entry, then voltage moved to the reset pin
  task automatic t_hv();
    entry(mme_pkg::MME_IRQ_TST, 8'h12, 1'b1, 1'b0, 1'b0);
    chk(7'h59);
    repeat (30) @(negedge clk);
    `CHK(cpar, 1'b0)
    rtst = 1'b1;
    irq = mme_pkg::MME_IRQ_VDD;
    repeat (4) @(negedge clk);
    `CHK(wd, 1'b1)
    rtst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(wd, 1'b0)
    entry(mme_pkg::MME_IRQ_TST, 8'h12, 1'b0, 1'b1, 1'b0);
    chk(7'h00);
  endtask : t_hv

  // blank vector with supply level, straps wrong, parallel chosen
  task automatic t_blank();
    entry(mme_pkg::MME_IRQ_VDD, 8'hFF, 1'b0, 1'b1, 1'b1);
    chk(7'h4E);
    `CHK(n_ext, 1)
    entry(mme_pkg::MME_IRQ_GND, 8'h12, 1'b0, 1'b0, 1'b0);
    chk(7'h4E);
    `CHK(n_ext, 1)
  endtask : t_blank

  // power-on clears the sticky mode, then the pll path is entered
  task automatic t_pll();
    por_n = 1'b0;
    repeat (3) @(negedge clk);
    por_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(7'h00);
    entry(mme_pkg::MME_IRQ_GND, 8'hFF, 1'b1, 1'b1, 1'b0);
    chk(7'h6B);
    `CHK(n_ext, 2)
  endtask : t_pll

  // generous bound: the whole sequence needs well under 500 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    por_n = 1'b1;
    t_user();
    t_hv();
    t_blank();
    t_pll();
    stop_test();
  end
endmodule : mme_decoder_tb
